// File: rtl/sbw_pkg.sv
// Shared types and constants of the byte and word steering block
package sbw_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Address field positions
	localparam int SBW_A0_BIT       = 0;
	localparam int SBW_WORD_LO_BIT  = 1;
	localparam int SBW_STD_TOP_BIT  = 15;
	localparam int SBW_EXT_LO_BIT   = 16;
	localparam int SBW_CONS_TOP_BIT = 13;
	localparam int SBW_BANK_LO_BIT  = 14;
	localparam int SBW_BANK_HI_BIT  = 15;
	localparam int SBW_BANK_CNT     = 4;

	////////////////////////////////////////////////////////////////////////////
	// Documented widths
	localparam int SBW_ADDR_W_STD = 16;
	localparam int SBW_ADDR_W_EXT = 24;
	localparam int SBW_BYTE_W     = 8;

	////////////////////////////////////////////////////////////////////////////
	// Operating modes, one-hot
	typedef enum logic [1:0] {
		SBW_MODE_STANDARD = 2'b01,
		SBW_MODE_CONSEC   = 2'b10
	} sbw_mode_t;

	// Bus status levels as seen at the board edge
	typedef struct packed {
		logic board_sel;
		logic bank_hit_n;
		logic pdbin;
		logic sxtrq_n;
		logic pwr_n;
		logic mrq;
		logic phantom_n;
		logic sinta;
	} sbw_status_t;

	// Decoded strobes
	typedef struct packed {
		logic byte_read_strobe;
		logic word_read_strobe;
		logic byte_write_strobe;
		logic word_write_strobe;
	} sbw_strobe_t;

	// Array and driver controls
	typedef struct packed {
		logic                    low_array_write_n;
		logic                    high_array_write_n;
		logic                    low_di_oe;
		logic                    high_di_oe;
		logic                    high_do_oe;
		logic [SBW_BANK_CNT-1:0] bank_row_n;
	} sbw_ctl_t;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam sbw_strobe_t SBW_STROBE_RST = '{
		byte_read_strobe:  1'b0,
		word_read_strobe:  1'b0,
		byte_write_strobe: 1'b0,
		word_write_strobe: 1'b0
	};
	localparam sbw_ctl_t SBW_CTL_RST = '{
		low_array_write_n:  1'b1,
		high_array_write_n: 1'b1,
		low_di_oe:          1'b0,
		high_di_oe:         1'b0,
		high_do_oe:         1'b0,
		bank_row_n:         4'hf
	};

endpackage

// File: rtl/sbw_sync.sv
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none

module sbw_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sbw_sync_state_t;

	sbw_sync_state_t state_q;
	sbw_sync_state_t state_d;

	// First stage feeds only the second stage
	always_comb begin
		state_d        = state_q;
		state_d.meta   = async_in;
		state_d.stable = state_q.meta;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign sync_out = state_q.stable;

endmodule

`default_nettype wire

// File: rtl/sbw_steering.sv
// Byte and word read/write steering for a 16-bit capable dynamic RAM board
//
// Behaviour
// - Byte read needs select, pDBIN, sXTRQ* high, no phantom, no sINTA, bank hit.
// - Word read same but sXTRQ* low; never together with byte read.
// - Byte write needs select, sXTRQ* high, pWR* low, memory request.
// - Word write same as byte write but with sXTRQ* low.
// - Low array write on word write, or byte write with A0 high.
// - High array write on word write, or byte write with A0 low, if enabled.
// - Consecutive mode: byte write strobes both arrays regardless of A0.
// - Low array onto DI on word read, or byte read with A0 high.
// - High array onto DI only on byte read with A0 low, or any byte read in consecutive mode.
// - High array onto DO bits 8-15 only during word read.
// - Consecutive mode: byte read enables both DI drivers regardless of A0.
// - Sequential mode: A1 upward selects word, A0 low high byte, high low byte.
// - Byte mode: DO data to low array, same DO data to high array.
// - Consecutive mode: A14-A15 pick the bank, A0-A13 go to the array.
// - Consecutive mode byte references: both writes, both DI drivers, unselected rows held high.
// - Standard mode: word references ignore A0 entirely.
// - Word mode: high array data from DI bus, low array from DO bus.
`timescale 1ns/1ps
`default_nettype none

module sbw_steering
	import sbw_pkg::*;
#(
	parameter int ADDR_W = SBW_ADDR_W_EXT,
	parameter int BYTE_W = SBW_BYTE_W
) (
	input  wire logic              clock,
	input  wire logic              arst_n,
	input  wire sbw_status_t       status,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              ext_addr_en,
	input  wire sbw_mode_t         mode,
	input  wire logic              high_write_en,
	input  wire logic [BYTE_W-1:0] do_in,
	input  wire logic [BYTE_W-1:0] di_in,
	input  wire logic [BYTE_W-1:0] low_rd_data,
	input  wire logic [BYTE_W-1:0] high_rd_data,
	output var  sbw_strobe_t       strobes,
	output var  sbw_ctl_t          ctl,
	output var  logic [ADDR_W-2:0] array_addr,
	output var  logic [BYTE_W-1:0] low_wr_data,
	output var  logic [BYTE_W-1:0] high_wr_data,
	output var  logic [BYTE_W-1:0] low_di_data,
	output var  logic [BYTE_W-1:0] high_di_data,
	output var  logic [BYTE_W-1:0] high_do_data
);

	////////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	generate
		if (ADDR_W != SBW_ADDR_W_STD && ADDR_W != SBW_ADDR_W_EXT) begin : g_bad_addr
			$error("sbw_steering: ADDR_W must be 16 or 24");
		end
		if (BYTE_W != SBW_BYTE_W) begin : g_bad_byte
			$error("sbw_steering: BYTE_W must be 8");
		end

		// Field positions must tile the address bus with no gap or overlap
		if (SBW_WORD_LO_BIT != SBW_A0_BIT + 1) begin : g_bad_word_lo
			$error("sbw_steering: word select must start just above the byte select");
		end
		if (SBW_STD_TOP_BIT + 1 != SBW_EXT_LO_BIT) begin : g_bad_std_top
			$error("sbw_steering: standard and extended address fields must meet");
		end
		if (SBW_EXT_LO_BIT != SBW_ADDR_W_STD) begin : g_bad_ext_lo
			$error("sbw_steering: extended field must start at the standard width");
		end
		if (SBW_CONS_TOP_BIT + 1 != SBW_BANK_LO_BIT) begin : g_bad_cons
			$error("sbw_steering: consecutive array field must end below the bank field");
		end
		if (SBW_BANK_CNT
			!= (1 << (SBW_BANK_HI_BIT - SBW_BANK_LO_BIT + 1))) begin : g_bad_bank
			$error("sbw_steering: bank count must match the bank select field");
		end
		if (SBW_BANK_HI_BIT >= ADDR_W) begin : g_bad_bank_top
			$error("sbw_steering: bank select field lies outside the address");
		end

		// Strobes and row selects must leave reset idle so no array is written
		if (SBW_STROBE_RST != '0) begin : g_bad_strobe_rst
			$error("sbw_steering: strobes must reset inactive");
		end
		if (SBW_CTL_RST.bank_row_n != '1 || !SBW_CTL_RST.low_array_write_n
			|| !SBW_CTL_RST.high_array_write_n) begin : g_bad_ctl_rst
			$error("sbw_steering: write and row strobes must reset high");
		end

		// Mode codes are one-hot; a shared bit would alias the two organisations
		if ((SBW_MODE_STANDARD & SBW_MODE_CONSEC) != 2'b00) begin : g_bad_mode
			$error("sbw_steering: mode codes must not share a bit");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation
	// All bus levels share one synchroniser so they stay aligned cycle for
	// cycle; skew on the wires themselves is still the board's problem.

	localparam int STATUS_W = $bits(sbw_status_t);
	localparam int MODE_W   = $bits(sbw_mode_t);
	localparam int SYNC_W   = STATUS_W + ADDR_W + 2 + MODE_W + 4 * BYTE_W;

	logic [SYNC_W-1:0] sync_raw;
	logic [SYNC_W-1:0] sync_vec;

	sbw_status_t       s_status;
	logic [ADDR_W-1:0] s_addr;
	logic              s_ext_en;
	logic [MODE_W-1:0] s_mode_bits;
	logic              s_hi_wr_en;
	logic [BYTE_W-1:0] s_do;
	logic [BYTE_W-1:0] s_di;
	logic [BYTE_W-1:0] s_low_rd;
	logic [BYTE_W-1:0] s_high_rd;

	assign sync_raw = {status, addr, ext_addr_en, mode, high_write_en,
		do_in, di_in, low_rd_data, high_rd_data};

	sbw_sync #(
		.W (SYNC_W)
	) u_sync (
		.clock    (clock),
		.arst_n   (arst_n),
		.async_in (sync_raw),
		.sync_out (sync_vec)
	);

	assign {s_status, s_addr, s_ext_en, s_mode_bits, s_hi_wr_en,
		s_do, s_di, s_low_rd, s_high_rd} = sync_vec;

	////////////////////////////////////////////////////////////////////////////
	// Registered state

	typedef struct packed {
		sbw_strobe_t       strobes;
		sbw_ctl_t          ctl;
		logic [ADDR_W-2:0] array_addr;
		logic [BYTE_W-1:0] low_wr_data;
		logic [BYTE_W-1:0] high_wr_data;
		logic [BYTE_W-1:0] low_di_data;
		logic [BYTE_W-1:0] high_di_data;
		logic [BYTE_W-1:0] high_do_data;
	} sbw_state_t;

	localparam sbw_state_t STATE_RST = '{
		strobes:      SBW_STROBE_RST,
		ctl:          SBW_CTL_RST,
		array_addr:   '0,
		low_wr_data:  '0,
		high_wr_data: '0,
		low_di_data:  '0,
		high_di_data: '0,
		high_do_data: '0
	};

	sbw_state_t state_q;
	sbw_state_t state_d;

	////////////////////////////////////////////////////////////////////////////
	// Decode

	logic              consec;
	logic              a0;
	logic [1:0]        bank_idx;
	logic              read_ok;
	logic              write_ok;
	logic              byte_rd;
	logic              word_rd;
	logic              byte_wr;
	logic              word_wr;
	logic              low_we;
	logic              high_we;
	logic              low_oe;
	logic              high_oe;
	logic [ADDR_W-1:0] std_addr;
	logic [ADDR_W-1:0] cons_addr;

	always_comb begin
		// Reserved mode codes fall back to the standard organisation
		case (s_mode_bits)
			SBW_MODE_CONSEC: begin
				consec = 1'b1;
			end
			default: begin
				consec = 1'b0;
			end
		endcase
		a0       = s_addr[SBW_A0_BIT];
		bank_idx = s_addr[SBW_BANK_HI_BIT:SBW_BANK_LO_BIT];

		// No bank hit, phantom or interrupt acknowledge blocks every read
		read_ok  = s_status.board_sel & s_status.pdbin & ~s_status.bank_hit_n
			& s_status.phantom_n & ~s_status.sinta;
		write_ok = s_status.board_sel & ~s_status.pwr_n & s_status.mrq;

		byte_rd = read_ok & s_status.sxtrq_n;
		word_rd = read_ok & ~s_status.sxtrq_n;
		byte_wr = write_ok & s_status.sxtrq_n;
		word_wr = write_ok & ~s_status.sxtrq_n;
	end

	////////////////////////////////////////////////////////////////////////////
	// Write steering

	always_comb begin
		low_we  = word_wr | (byte_wr & (a0 | consec));
		high_we = (s_hi_wr_en & (word_wr | (byte_wr & ~a0)))
			| (consec & byte_wr);
	end

	////////////////////////////////////////////////////////////////////////////
	// Read steering

	always_comb begin
		low_oe  = word_rd | (byte_rd & (a0 | consec));
		high_oe = byte_rd & (~a0 | consec);
	end

	////////////////////////////////////////////////////////////////////////////
	// Array address

	always_comb begin
		// Word select ignores A0; top bits only with extended addressing
		std_addr = s_addr;
		if (!s_ext_en) begin
			std_addr = {{(ADDR_W - SBW_EXT_LO_BIT){1'b0}},
				s_addr[SBW_STD_TOP_BIT:0]};
		end
		cons_addr = {{(ADDR_W - SBW_CONS_TOP_BIT - 1){1'b0}},
			s_addr[SBW_CONS_TOP_BIT:0]};
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		state_d = state_q;

		state_d.strobes.byte_read_strobe  = byte_rd;
		state_d.strobes.word_read_strobe  = word_rd;
		state_d.strobes.byte_write_strobe = byte_wr;
		state_d.strobes.word_write_strobe = word_wr;

		state_d.ctl.low_array_write_n  = ~low_we;
		state_d.ctl.high_array_write_n = ~high_we;

		state_d.ctl.low_di_oe  = low_oe;
		state_d.ctl.high_di_oe = high_oe;
		state_d.ctl.high_do_oe = word_rd;

		// Rows of unselected banks stay high so their outputs float
		state_d.ctl.bank_row_n = '1;
		if (consec && (byte_rd || byte_wr)) begin
			state_d.ctl.bank_row_n[bank_idx] = 1'b0;
		end

		if (consec) begin
			state_d.array_addr = cons_addr[ADDR_W-2:0];
		end else begin
			state_d.array_addr = std_addr[ADDR_W-1:SBW_WORD_LO_BIT];
		end

		state_d.low_wr_data = s_do;
		if (s_status.sxtrq_n) begin
			state_d.high_wr_data = s_do;
		end else begin
			state_d.high_wr_data = s_di;
		end

		// Read data always follows the arrays; the enables decide who drives
		state_d.low_di_data  = s_low_rd;
		state_d.high_di_data = s_high_rd;
		state_d.high_do_data = s_high_rd;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= STATE_RST;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign strobes      = state_q.strobes;
	assign ctl          = state_q.ctl;
	assign array_addr   = state_q.array_addr;
	assign low_wr_data  = state_q.low_wr_data;
	assign high_wr_data = state_q.high_wr_data;
	assign low_di_data  = state_q.low_di_data;
	assign high_di_data = state_q.high_di_data;
	assign high_do_data = state_q.high_do_data;

endmodule

`default_nettype wire

// File: testbench/sbw_steering_sva.sv
// Assertions on the steering block outputs
`timescale 1ns/1ps
`default_nettype none

module sbw_steering_sva
	import sbw_pkg::*;
#(
	parameter int ADDR_W = 24
) (
	input wire logic              clock,
	input wire logic              arst_n,
	input wire sbw_status_t       status,
	input wire logic [ADDR_W-1:0] addr,
	input wire sbw_mode_t         mode,
	input wire logic              high_write_en,
	input wire sbw_strobe_t       strobes,
	input wire sbw_ctl_t          ctl
);

	////////////////////////////////////////////////////////////////////////////
	// Expected levels from the pins; outputs trail them by three edges
	logic [1:0] up_q;
	logic       rd, wr, cs, brd, wrd, bwr, wwr, lwe, hwe, ldi, hdi;
	logic [3:0] row;
	assign rd  = status.board_sel & status.pdbin & ~status.bank_hit_n & status.phantom_n & ~status.sinta;
	assign wr  = status.board_sel & ~status.pwr_n & status.mrq;
	assign cs  = mode == SBW_MODE_CONSEC;
	assign brd = rd & status.sxtrq_n;
	assign wrd = rd & ~status.sxtrq_n;
	assign bwr = wr & status.sxtrq_n;
	assign wwr = wr & ~status.sxtrq_n;
	assign lwe = wwr | bwr & (addr[0] | cs);
	assign hwe = high_write_en & (wwr | bwr & ~addr[0]) | cs & bwr;
	assign ldi = wrd | brd & (addr[0] | cs);
	assign hdi = brd & (~addr[0] | cs);
	assign row = (cs & (brd | bwr)) ? ~(4'h1 << addr[15:14]) : 4'hf;

	// Pipeline still holds cleared values for three edges after reset
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			up_q <= 2'h0;
		end else if (up_q != 2'h3) begin
			up_q <= up_q + 2'h1;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	////////////////////////////////////////////////////////////////////////////
	property p_brd; up_q == 2'h3 |-> strobes.byte_read_strobe == $past(brd, 3); endproperty
	a_brd: assert property (p_brd) else $error("byte read strobe off");
	property p_wrd; up_q == 2'h3 |-> strobes.word_read_strobe == $past(wrd, 3); endproperty
	a_wrd: assert property (p_wrd) else $error("word read strobe off");
	property p_excl; !(strobes.byte_read_strobe && strobes.word_read_strobe); endproperty
	a_excl: assert property (p_excl) else $error("both read strobes");
	property p_bwr; up_q == 2'h3 |-> strobes.byte_write_strobe == $past(bwr, 3); endproperty
	a_bwr: assert property (p_bwr) else $error("byte write strobe off");
	property p_wwr; up_q == 2'h3 |-> strobes.word_write_strobe == $past(wwr, 3); endproperty
	a_wwr: assert property (p_wwr) else $error("word write strobe off");
	property p_lwe; up_q == 2'h3 |-> ctl.low_array_write_n != $past(lwe, 3); endproperty
	a_lwe: assert property (p_lwe) else $error("low array write off");
	property p_hwe; up_q == 2'h3 |-> ctl.high_array_write_n != $past(hwe, 3); endproperty
	a_hwe: assert property (p_hwe) else $error("high array write off");
	property p_ldi; up_q == 2'h3 |-> ctl.low_di_oe == $past(ldi, 3); endproperty
	a_ldi: assert property (p_ldi) else $error("low driver enable off");
	property p_hdi; up_q == 2'h3 |-> ctl.high_di_oe == $past(hdi, 3); endproperty
	a_hdi: assert property (p_hdi) else $error("high driver enable off");
	property p_hdo; up_q == 2'h3 |-> ctl.high_do_oe == $past(wrd, 3); endproperty
	a_hdo: assert property (p_hdo) else $error("high out driver off");
	property p_row; up_q == 2'h3 |-> ctl.bank_row_n == $past(row, 3); endproperty
	a_row: assert property (p_row) else $error("bank row strobe off");

endmodule

bind sbw_steering sbw_steering_sva #(.ADDR_W(ADDR_W)) sbw_steering_sva_inst (.clock, .arst_n,
	.status, .addr, .mode, .high_write_en, .strobes, .ctl);

`default_nettype wire

// File: testbench/sbw_mst.sv
// Bus master model driving status, address and data pins
`timescale 1ns/1ps
`default_nettype none

module sbw_mst
	import sbw_pkg::*;
(
	input  wire logic        clock,
	output var  sbw_status_t status,
	output var  logic [23:0] addr,
	output var  logic [7:0]  do_in,
	output var  logic [7:0]  di_in
);

	initial begin
		status = 8'h5a;
		addr = 24'h0;
		do_in = 8'h0;
		di_in = 8'h0;
	end

	// One idle cycle with inverted data, then the access, held until it settles
	task automatic cyc(input logic [7:0] st, input logic [23:0] a, input logic [7:0] dl, dh);
		@(posedge clock);
		#1;
		status = 8'h5a;
		do_in = ~do_in;
		di_in = ~di_in;
		@(posedge clock);
		#1;
		status = st;
		addr = a;
		do_in = dl;
		di_in = dh;
		repeat (4) @(posedge clock);
		#1;
	endtask

endmodule

`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the steering block
`timescale 1ns/1ps
`default_nettype none

module tb
	import sbw_pkg::*;
;
	logic        clock, arst_n, ext_addr_en, high_write_en;
	sbw_mode_t   mode;
	sbw_status_t status;
	sbw_strobe_t strobes;
	sbw_ctl_t    ctl;
	logic [23:0] addr;
	logic [22:0] array_addr;
	logic [7:0]  do_in, di_in, low_rd_data, high_rd_data, low_wr_data, high_wr_data;
	logic [7:0]  low_di_data, high_di_data, high_do_data;
	int          err_total, cmp_count;

	sbw_mst sbw_mst_inst (.clock, .status, .addr, .do_in, .di_in);
	sbw_steering sbw_steering_inst (.clock, .arst_n, .status, .addr, .ext_addr_en, .mode,
		.high_write_en, .do_in, .di_in, .low_rd_data, .high_rd_data, .strobes, .ctl,
		.array_addr, .low_wr_data, .high_wr_data, .low_di_data, .high_di_data, .high_do_data);

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic look(input logic [8:0] e);
		chk({strobes, ctl[8:4]}, e);
	endtask

	task automatic stop_test;
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// High byte first, then low byte, as a sequential word
	task automatic t_byte_rd;
		for (int i = 0; i < 2; i++) begin
			sbw_mst_inst.cyc(8'hba, {23'h091a2b, i[0]}, 8'h0, 8'h0);
			look({4'h8, 2'b11, i[0], !i[0], 1'b0});
			chk(i ? low_di_data : high_di_data, i ? low_rd_data : high_rd_data);
			chk(array_addr, 23'h091a2b);
		end
	endtask

	task automatic t_word_rd;
		for (int i = 0; i < 2; i++) begin
			sbw_mst_inst.cyc(8'haa, {23'h091a2b, i[0]}, 8'h0, 8'h0);
			look({4'h4, 2'b11, 3'b101});
			chk(high_do_data, high_rd_data);
			chk(array_addr, 23'h091a2b);
		end
	endtask

	task automatic t_blocked;
		logic [7:0] bad [8] = '{8'h3a, 8'h9a, 8'hfa, 8'hb8, 8'hbb, 8'h56, 8'hde, 8'hd2};
		for (int i = 0; i < 8; i++) begin
			sbw_mst_inst.cyc(bad[i], 24'h0, 8'h0, 8'h0);
			look(9'h018);
		end
	endtask

	task automatic t_writes;
		for (int h = 0; h < 2; h++) begin
			for (int i = 0; i < 2; i++) begin
				high_write_en = h[0];
				sbw_mst_inst.cyc(8'hd6, {23'h0a0b0c, i[0]}, 8'h5e, 8'ha7);
				look({4'h2, !i[0], !(h[0] & !i[0]), 3'b0});
				chk({low_wr_data, high_wr_data}, 16'h5e5e);
				sbw_mst_inst.cyc(8'hc6, {23'h0a0b0c, i[0]}, 8'h5e, 8'ha7);
				look({4'h1, 1'b0, !h[0], 3'b0});
				chk({low_wr_data, high_wr_data}, 16'h5ea7);
			end
		end
	endtask

	// Consecutive mode banks, then narrow array address when the upper lines are switched off
	task automatic t_consec;
		mode = SBW_MODE_CONSEC;
		high_write_en = 1'b0;
		for (int i = 0; i < 2; i++) begin
			sbw_mst_inst.cyc(8'hd6, 24'h00c000 | 24'(i), 8'h11, 8'h22);
			look({4'h2, 2'b00, 3'b0});
			chk(ctl.bank_row_n, 4'h7);
			sbw_mst_inst.cyc(8'hba, 24'h00b3c4 | 24'(i), 8'h0, 8'h0);
			look({4'h8, 2'b11, 3'b110});
			chk(array_addr, 23'h0033c4 | i);
			chk(ctl.bank_row_n, 4'hb);
		end
		mode = SBW_MODE_STANDARD;
		ext_addr_en = 1'b0;
		sbw_mst_inst.cyc(8'hba, 24'habcdef, 8'h0, 8'h0);
		chk(array_addr, 23'h0066f7);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial begin
		#1_000_000;
		err_total++;
		stop_test;
	end

	initial begin
		arst_n = 1'b0;
		mode = SBW_MODE_STANDARD;
		ext_addr_en = 1'b1;
		high_write_en = 1'b1;
		low_rd_data = 8'h3c;
		high_rd_data = 8'hc5;
		err_total = 0;
		cmp_count = 0;
		repeat (12) @(posedge clock);
		#1;
		arst_n = 1'b1;
		t_byte_rd;
		t_word_rd;
		t_blocked;
		t_writes;
		t_consec;
		stop_test;
	end

endmodule

`default_nettype wire
